/* logic/ssl_regs.svh */
// Timing counts and encodings for the status lamp driver.
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH
`define SSL_CLK_MHZ 100
`define SSL_BOOT_MS 20000
`define SSL_BOOT_CYCLES (`SSL_BOOT_MS * 1000 * `SSL_CLK_MHZ)
`define SSL_FLASH_MS 50
`define SSL_FLASH_CYCLES (`SSL_FLASH_MS * 1000 * `SSL_CLK_MHZ)
`define SSL_SPEED_10 2'h0
`define SSL_SPEED_100 2'h1
`define SSL_SPEED_1000 2'h2
`define SSL_LEVEL_W 8
`endif

/* logic/ssl_pkg.sv */
// Types shared by the status lamp driver.
package ssl_pkg;
  typedef logic [1:0] ssl_speed_t;
  typedef logic [7:0] ssl_level_t;
  typedef enum logic [1:0] {SSL_BOOTING = 2'h1, SSL_RUNNING = 2'h2} ssl_boot_t;
endpackage

/* logic/ssl_lamp_driver.sv */
// Front-panel status lamp driver for a subscriber or backhaul slave radio unit.
// Behaviour
// - Operating mode shows registration and traffic status.
// - Aiming mode lamps show received signal strength.
// - Three lamps form bar graph in aiming.
// - Lock lamp follows sync in operating mode.
// - Registration lamp follows session in operating mode.
// - Traffic lamp flashes on Ethernet activity always.
// - Wired lamp lit on link, speed colour.
// - Supply lamp steady within boot interval, stays.
`timescale 1ns/1ps
`include "ssl_regs.svh"
module ssl_lamp_driver #(
  parameter int unsigned BOOT_CYCLES = `SSL_BOOT_CYCLES, // Boot interval in cycles.
  parameter int unsigned FLASH_CYCLES = `SSL_FLASH_CYCLES // Half period of traffic flash.
) (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic aimingMode, // High selects aiming mode.
  input wire logic syncLocked, // Unit synchronised to its master.
  input wire logic sessionActive, // Unit holds an active session.
  input wire logic ethActivity, // Ethernet data is moving.
  input wire logic ethLinkUp, // Ethernet link is up.
  input wire ssl_pkg::ssl_speed_t ethSpeed, // Link speed code.
  input wire logic singleColour, // High for a green-only wired lamp.
  input wire ssl_pkg::ssl_level_t rxLevel, // Received signal quality.
  input wire ssl_pkg::ssl_level_t thresh1, // Level for first segment.
  input wire ssl_pkg::ssl_level_t thresh2, // Level for second segment.
  input wire ssl_pkg::ssl_level_t thresh3, // Level for third segment.
  output logic supplyLamp, // Supply lamp drive.
  output logic lockLamp, // Lock lamp, bar segment one.
  output logic registrationLamp, // Registration lamp, bar segment two.
  output logic thirdLamp, // Bar segment three, dark in operating mode.
  output logic trafficLamp, // Traffic lamp drive.
  output logic wireRed, // Wired-link lamp red element.
  output logic wireGreen, // Wired-link lamp green element.
  output logic passTraffic // High when the unit may register and pass traffic.
);
  import ssl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Supply lamp: lit once the boot interval has run out.
  logic [31:0] bootCnt_q;
  ssl_boot_t bootState_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bootCnt_q <= 32'h0;
      bootState_q <= SSL_BOOTING;
      supplyLamp <= 1'b0;
    end else begin
      unique case (bootState_q)
        SSL_BOOTING: begin
          bootCnt_q <= bootCnt_q + 32'h1;
          if (bootCnt_q >= BOOT_CYCLES - 1) begin
            bootState_q <= SSL_RUNNING;
            supplyLamp <= 1'b1;
          end
        end
        SSL_RUNNING: begin
          supplyLamp <= 1'b1;
        end
        default: begin
          bootState_q <= SSL_BOOTING;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bar graph levels; each segment is compared against its own threshold.
  // The thresholds are inputs because the alignment boundaries are left to firmware.
  wire ssl_level_t segThresh [3];
  wire [2:0] bar;
  assign segThresh[0] = thresh1;
  assign segThresh[1] = thresh2;
  assign segThresh[2] = thresh3;
  // thermometer code
  // A segment is gated by the one below, so a badly ordered threshold set
  // still shows a solid bar rather than gaps that would confuse an installer.
  for (genvar g = 0; g < 3; g++) begin : gen_seg
    if (g == 0) begin : gen_first
      assign bar[g] = rxLevel >= segThresh[g];
    end else begin : gen_upper
      assign bar[g] = bar[g - 1] && (rxLevel >= segThresh[g]);
    end
  end

  // Mode mux for the three shared lamps.
  // Aiming drops passTraffic so the radio neither registers nor forwards while aimed.
  // mode selected meaning
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lockLamp <= 1'b0;
      registrationLamp <= 1'b0;
      thirdLamp <= 1'b0;
      passTraffic <= 1'b0;
    end else if (aimingMode) begin
      lockLamp <= bar[0];
      registrationLamp <= bar[1];
      thirdLamp <= bar[2];
      passTraffic <= 1'b0;
    end else begin
      lockLamp <= syncLocked;
      registrationLamp <= sessionActive;
      thirdLamp <= 1'b0;
      passTraffic <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Traffic flash; the rate carries no meaning so a free-running toggle is enough.
  logic [31:0] flashCnt_q;
  logic flashPhase_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flashCnt_q <= 32'h0;
      flashPhase_q <= 1'b0;
      trafficLamp <= 1'b0;
    end else begin
      if (flashCnt_q >= FLASH_CYCLES - 1) begin
        flashCnt_q <= 32'h0;
        flashPhase_q <= ~flashPhase_q;
      end else begin
        flashCnt_q <= flashCnt_q + 32'h1;
      end
      trafficLamp <= ethActivity && flashPhase_q;
    end
  end

  // Wired-link lamp colour; orange is both elements lit.
  // speed colour
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wireRed <= 1'b0;
      wireGreen <= 1'b0;
    end else if (!ethLinkUp) begin
      wireRed <= 1'b0;
      wireGreen <= 1'b0;
    end else if (singleColour) begin
      wireRed <= 1'b0;
      wireGreen <= 1'b1;
    end else begin
      wireRed <= (ethSpeed == `SSL_SPEED_10) || (ethSpeed == `SSL_SPEED_1000);
      wireGreen <= (ethSpeed != `SSL_SPEED_10);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Helper counters for the checks below; they only watch inputs and outputs.
  logic [31:0] upCycles_q;
  logic [31:0] darkRun_q;
  logic [31:0] litRun_q;
  // Cycles since reset, held at its ceiling so a long run cannot wrap it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upCycles_q <= 32'h0;
    end else if (upCycles_q != 32'hFFFFFFFF) begin
      upCycles_q <= upCycles_q + 32'h1;
    end
  end
  // Lengths of the current dark stretch while data moves and of the current lit stretch.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      darkRun_q <= 32'h0;
      litRun_q <= 32'h0;
    end else begin
      darkRun_q <= (ethActivity && !trafficLamp) ? darkRun_q + 32'h1 : 32'h0;
      litRun_q <= trafficLamp ? litRun_q + 32'h1 : 32'h0;
    end
  end

  // Operating-mode lamp meanings; lock and registration lamps follow their flags one cycle late, third lamp dark.
  a_lock_follow: assert property (@(posedge clk) disable iff (!reset_n)
    !aimingMode |=> lockLamp == $past(syncLocked)) else $error("lock lamp wrong");
  a_reg_follow: assert property (@(posedge clk) disable iff (!reset_n)
    !aimingMode |=> registrationLamp == $past(sessionActive)) else $error("registration lamp wrong");
  a_op_pass: assert property (@(posedge clk) disable iff (!reset_n)
    !aimingMode |=> passTraffic && !thirdLamp) else $error("operating mode wrong");

  // Aiming-mode bar graph; traffic is held off while the installer aims.
  a_aim_block: assert property (@(posedge clk) disable iff (!reset_n)
    aimingMode |=> !passTraffic) else $error("traffic passed in aiming");
  a_bar_thermo: assert property (@(posedge clk) disable iff (!reset_n)
    aimingMode |=> (!thirdLamp || registrationLamp) && (!registrationLamp || lockLamp)) else $error("bar not thermometer");
  a_bar_level: assert property (@(posedge clk) disable iff (!reset_n)
    aimingMode |=> lockLamp == ($past(rxLevel) >= $past(thresh1))) else $error("bar segment wrong");
  a_bar_top: assert property (@(posedge clk) disable iff (!reset_n)
    aimingMode |=> thirdLamp == ($past(rxLevel) >= $past(thresh1) && $past(rxLevel) >= $past(thresh2)
      && $past(rxLevel) >= $past(thresh3))) else $error("top segment wrong");

  // Traffic lamp: dark when idle, and neither stuck dark nor stuck lit while data moves.
  a_traffic_dark: assert property (@(posedge clk) disable iff (!reset_n)
    !ethActivity |=> !trafficLamp) else $error("traffic lamp lit idle");
  a_flash_lights: assert property (@(posedge clk) disable iff (!reset_n)
    darkRun_q <= FLASH_CYCLES + 1) else $error("traffic lamp stuck dark");
  a_flash_blinks: assert property (@(posedge clk) disable iff (!reset_n)
    litRun_q <= FLASH_CYCLES) else $error("traffic lamp stuck lit");

  // Wired-link lamp colour for each speed, and for the green-only lamp.
  a_wire_colour: assert property (@(posedge clk) disable iff (!reset_n)
    ethLinkUp && !singleColour && ethSpeed == `SSL_SPEED_100 |=> wireGreen && !wireRed)
    else $error("wire colour wrong");
  a_wire_red: assert property (@(posedge clk) disable iff (!reset_n)
    ethLinkUp && !singleColour && ethSpeed == `SSL_SPEED_10 |=> wireRed && !wireGreen)
    else $error("wire red wrong");
  a_wire_orange: assert property (@(posedge clk) disable iff (!reset_n)
    ethLinkUp && !singleColour && ethSpeed == `SSL_SPEED_1000 |=> wireRed && wireGreen)
    else $error("wire orange wrong");
  a_wire_single: assert property (@(posedge clk) disable iff (!reset_n)
    ethLinkUp && singleColour |=> wireGreen && !wireRed) else $error("single colour lamp wrong");
  a_wire_off: assert property (@(posedge clk) disable iff (!reset_n)
    !ethLinkUp |=> !wireGreen && !wireRed) else $error("wire lamp lit without link");

  // Supply lamp: lit by the end of the boot interval and never dropped after.
  a_supply_stay: assert property (@(posedge clk) disable iff (!reset_n)
    supplyLamp |=> supplyLamp) else $error("supply lamp dropped");
  a_supply_late: assert property (@(posedge clk) disable iff (!reset_n)
    upCycles_q >= BOOT_CYCLES |-> supplyLamp) else $error("supply lamp late");

  // Scenarios that the bench is expected to reach.
  c_aim_full: cover property (@(posedge clk) disable iff (!reset_n) thirdLamp);
  c_supply_on: cover property (@(posedge clk) disable iff (!reset_n) $rose(supplyLamp));
  c_flash: cover property (@(posedge clk) disable iff (!reset_n) $rose(trafficLamp));
  c_orange: cover property (@(posedge clk) disable iff (!reset_n) wireRed && wireGreen);
  c_aim_flash: cover property (@(posedge clk) disable iff (!reset_n) aimingMode && trafficLamp);
endmodule // ssl_lamp_driver

/* verification/ssl_lamp_viewer.sv */
// Installer's view of the lamp panel: wired-lamp colour and traffic flash count.
`timescale 1ns/1ps
module ssl_lamp_viewer (
  input wire logic clk, // System clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic wireRed, // Red element of the wired lamp.
  input wire logic wireGreen, // Green element of the wired lamp.
  input wire logic trafficLamp, // Traffic lamp.
  output logic [1:0] colour, // Seen colour: 0 dark, 1 red, 2 green, 3 orange.
  output int flashes // Dark-to-lit changes of the traffic lamp.
);
  logic lastTraffic_q;
  // Both elements lit blend to orange for the eye.
  assign colour = {wireGreen, wireRed};
  // A steady lamp counts once only, so a real flash shows as several counts.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lastTraffic_q <= 1'b0;
      flashes <= 0;
    end else begin
      lastTraffic_q <= trafficLamp;
      flashes <= flashes + int'(trafficLamp && !lastTraffic_q);
    end
  end
endmodule // ssl_lamp_viewer

/* verification/subscriber_status_lamp_driver_test.sv */
// Self-checking bench for the status lamp driver.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module subscriber_status_lamp_driver_test;
  import ssl_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, aimingMode = 1'b0, syncLocked = 1'b0, sessionActive = 1'b0;
  logic ethActivity = 1'b0, ethLinkUp = 1'b0, singleColour = 1'b0;
  ssl_speed_t ethSpeed = 2'h0;
  ssl_level_t rxLevel = 8'h00, thresh1 = 8'h0A, thresh2 = 8'h14, thresh3 = 8'h1E;
  logic supplyLamp, lockLamp, registrationLamp, thirdLamp, trafficLamp, wireRed, wireGreen, passTraffic;
  logic [1:0] colour;
  int flashes, f0, lit, mismatches = 0, samplesChecked = 0, cycles = 0;
  ssl_level_t levels[6] = '{8'h05, 8'h0A, 8'h13, 8'h19, 8'h1E, 8'hFF};
  always #5 clk = ~clk;
  ssl_lamp_driver #(.BOOT_CYCLES(20), .FLASH_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n),
    .aimingMode(aimingMode), .syncLocked(syncLocked), .sessionActive(sessionActive), .ethActivity(ethActivity),
    .ethLinkUp(ethLinkUp), .ethSpeed(ethSpeed), .singleColour(singleColour), .rxLevel(rxLevel),
    .thresh1(thresh1), .thresh2(thresh2), .thresh3(thresh3), .supplyLamp(supplyLamp), .lockLamp(lockLamp),
    .registrationLamp(registrationLamp), .thirdLamp(thirdLamp), .trafficLamp(trafficLamp),
    .wireRed(wireRed), .wireGreen(wireGreen), .passTraffic(passTraffic));
  ssl_lamp_viewer viewer (.clk(clk), .reset_n(reset_n), .wireRed(wireRed), .wireGreen(wireGreen),
    .trafficLamp(trafficLamp), .colour(colour), .flashes(flashes));
  ////////////////////////////////////////////////////////////////////////////////
  // Inputs always change one nanosecond after the edge, away from sampling.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Expected bar segments; a segment needs every lower threshold met as well.
  function automatic logic [2:0] bar(input ssl_level_t rx);
    bar[0] = rx >= thresh1;
    bar[1] = bar[0] && rx >= thresh2;
    bar[2] = bar[1] && rx >= thresh3;
  endfunction
  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A hang is cut short well beyond the 122 or so cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_sim();
    end
  end
  // Main sequence.
  initial begin
    step(3);
    reset_n = 1'b1;
    step(10);
    `CHK("supply early", 1'b0, supplyLamp)
    step(15);
    `CHK("supply lit", 1'b1, supplyLamp)
    for (int i = 0; i < 4; i++) begin
      syncLocked = i[0];
      sessionActive = i[1];
      step(1);
      `CHK("lock", i[0], lockLamp)
      `CHK("session", i[1], registrationLamp)
      `CHK("operating", 2'h1, {thirdLamp, passTraffic})
    end
    aimingMode = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (i == 6) thresh1 = 8'h32;
      rxLevel = (i == 6) ? 8'h28 : levels[i];
      step(1);
      `CHK("bar", bar(rxLevel), {thirdLamp, registrationLamp, lockLamp})
      `CHK("aim pass", 1'b0, passTraffic)
    end
    for (int i = 0; i < 9; i++) begin
      ethSpeed = i[1:0];
      singleColour = i[2];
      ethLinkUp = (i < 8);
      step(1);
      `CHK("wire", (i == 8) ? 2'h0 : (i[2] || i[0]) ? 2'h2 : i[1] ? 2'h3 : 2'h1, colour)
    end
    // The traffic lamp must flash the same way in operating and in aiming mode.
    for (int m = 0; m < 2; m++) begin
      aimingMode = m[0];
      ethActivity = 1'b1;
      step(2);
      f0 = flashes;
      lit = 0;
      repeat (24) begin
        step(1);
        lit += int'(trafficLamp);
      end
      `CHK("traffic lit", 12, lit)
      `CHK("traffic flashes", 3, flashes - f0)
      ethActivity = 1'b0;
      step(3);
      lit = 0;
      repeat (8) begin
        step(1);
        lit += int'(trafficLamp !== 1'b0);
      end
      `CHK("traffic idle", 0, lit)
    end
    end_sim();
  end
endmodule // subscriber_status_lamp_driver_test
